// ### rtl/rst_seq_pkg.sv
// Constants and carrier types for the chip reset entry and state indicator.
// Assumes one clock (the crystal input clock) at 125 MHz.
package rst_seq_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned SYNC_STAGES     = 3;
  localparam int unsigned HOLD_BYPASS_CYC = 512;
  localparam int unsigned LOCK_TIME_US    = 100;
  localparam int unsigned LOCK_BASE_CYC   =
    (LOCK_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned RATIO_W         = 8;
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned SETTLE_TIME_US  = 8;

  typedef enum logic [1:0] {
    ST_IN_RESET,
    ST_HOLD,
    ST_RUN
  } seq_state_t;

  typedef struct packed {
    logic                 pll_enable;
    logic [RATIO_W-1:0]   vco_ratio;
  } pll_cfg_t;
endpackage

// ### rtl/reset_input_sync_and_status.sv
// Reset input synchroniser and reset-state output with hold counter.
// Assumes clock_i is the crystal input clock and rstn_i a block reset on
// that clock; pll_cfg_i comes from straps that stay put while the chip is
// out of reset, so it is read without a synchroniser.
`timescale 1ns/1ns

// Notes on behaviour
// - The reset pin passes three flip-flops on the crystal clock first.
// - A dedicated output is active while the chip is in reset.
// - With the PLL off the output stays active 512 cycles after release.
// - With the PLL on the output stays 100 us times the VCO ratio.
module reset_input_sync_and_status #(
  parameter int unsigned LOCK_BASE = rst_seq_pkg::LOCK_BASE_CYC
) (
  input  wire logic                  clock_i,
  input  wire logic                  rstn_i,
  input  wire logic                  ext_rst_n_i,
  input  wire rst_seq_pkg::pll_cfg_t pll_cfg_i,
  output logic                       chip_rst_state_out_o,
  output logic                       core_rst_n_o
);

  logic [rst_seq_pkg::SYNC_STAGES-1:0] sync_q;
  logic [rst_seq_pkg::CNT_W-1:0]       cnt_q;
  logic [rst_seq_pkg::CNT_W-1:0]       cnt_d;
  logic [rst_seq_pkg::CNT_W-1:0]       hold_len;
  logic [rst_seq_pkg::CNT_W-1:0]       lock_len;
  rst_seq_pkg::seq_state_t             state_q;
  rst_seq_pkg::seq_state_t             state_d;
  logic                                out_q;
  wire logic                           rst_seen;
  wire logic                           expired;
  logic [rst_seq_pkg::CNT_W-1:0]       hold_cyc_q;
  logic [rst_seq_pkg::CNT_W-1:0]       hold_cyc_d;

  // State decode shared by the sequencer checks; one place to change it
  function automatic logic in_hold(input rst_seq_pkg::seq_state_t st);
    return (st == rst_seq_pkg::ST_HOLD);
  endfunction

  // Three-stage chain; only the last stage is read by logic
  // Reset to 'seen' so the chip stays in reset until the pin is sampled
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[rst_seq_pkg::SYNC_STAGES-2:0], ext_rst_n_i};
    end
  end

  assign rst_seen = ~sync_q[rst_seq_pkg::SYNC_STAGES-1];

  // Hold length: fixed count in bypass, lock time scaled by ratio otherwise
  // Straps are read combinationally; a change mid-hold does not alter the count loaded at release
  assign lock_len = rst_seq_pkg::CNT_W'(LOCK_BASE * pll_cfg_i.vco_ratio);
  assign hold_len = pll_cfg_i.pll_enable ? lock_len
                  : rst_seq_pkg::CNT_W'(rst_seq_pkg::HOLD_BYPASS_CYC);
  // Expiry at one, not zero, so a loaded count of N gives N cycles of hold;
  // zero also counts so a ratio of zero cannot wedge the sequencer
  assign expired  = (cnt_q == 24'h000001) || (cnt_q == 24'h000000);

  // Cycles spent in hold; only the checks read it, to measure the hold
  assign hold_cyc_d = in_hold(state_q) ? hold_cyc_q + 24'h000001 : '0;

  // Sequencer; a ratio of zero is treated as one cycle of hold
  // A reset seen at any point sends it back to the start, so a pulse in
  // the middle of a PLL hold gives the PLL its full lock time again
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      rst_seq_pkg::ST_IN_RESET: begin
        // Reloaded every cycle here, so the strap value at release wins
        cnt_d = hold_len;
        if (!rst_seen) begin
          state_d = rst_seq_pkg::ST_HOLD;
        end
      end
      rst_seq_pkg::ST_HOLD: begin
        if (rst_seen) begin
          state_d = rst_seq_pkg::ST_IN_RESET;
        end else if (expired) begin
          state_d = rst_seq_pkg::ST_RUN;
          cnt_d   = '0;
        end else begin
          cnt_d = cnt_q - 24'h000001;
        end
      end
      rst_seq_pkg::ST_RUN: begin
        // Hot reset from the running state starts the whole sequence over
        if (rst_seen) begin
          state_d = rst_seq_pkg::ST_IN_RESET;
        end
      end
      default: begin
        // Unused encoding: recover into reset
        state_d = rst_seq_pkg::ST_IN_RESET;
      end
    endcase
  end

  // Output registered so it cannot glitch at the state change
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_q <= rst_seq_pkg::ST_IN_RESET;
      cnt_q   <= '0;
      out_q   <= 1'b1;
      hold_cyc_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      hold_cyc_q <= hold_cyc_d;
      out_q   <= (state_d != rst_seq_pkg::ST_RUN);
    end
  end

  assign chip_rst_state_out_o = out_q;
  assign core_rst_n_o         = ~out_q;

  // Bypass hold: output still active 8 cycles after hold entry
  property p_bypass_hold;
    @(posedge clock_i) disable iff (!rstn_i)
    ($rose(state_q == rst_seq_pkg::ST_HOLD) && !pll_cfg_i.pll_enable
      && !rst_seen)
      ##1 (!rst_seen)[*8] |-> chip_rst_state_out_o;
  endproperty
  a_bypass_hold_min: assert property (p_bypass_hold)
    else $error("reset state released too early in bypass");

  a_reset_drives_out: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    rst_seen |=> chip_rst_state_out_o)
    else $error("reset state not shown during reset");

  a_restart_on_reset: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    (in_hold(state_q) && rst_seen)
      |=> state_q == rst_seq_pkg::ST_IN_RESET)
    else $error("hold not restarted by reset");

  a_release_on_expiry: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $fell(chip_rst_state_out_o) |-> $past(expired))
    else $error("reset state dropped before expiry");

  a_sync_latency: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    $fell(ext_rst_n_i) ##1 (!ext_rst_n_i)[*2] |=> rst_seen)
    else $error("sync chain latency wrong");

  a_count_down: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    (in_hold(state_q) && !rst_seen && !expired)
      |=> cnt_q == $past(cnt_q) - 24'h000001)
    else $error("hold counter not decrementing");

  // Checks that measure the whole hold rather than its first cycles. The
  // hold counter above is the yardstick; a fall of the output must land
  // exactly on the length for the mode that the straps select; a PLL ratio of zero is not checked.
  sequence s_pin_released;
    $fell(rst_seen) && state_q == rst_seq_pkg::ST_IN_RESET;
  endsequence

  sequence s_hold_loaded;
    in_hold(state_q) && cnt_q == hold_len;
  endsequence

  sequence s_bypass_fall;
    $fell(chip_rst_state_out_o) && !pll_cfg_i.pll_enable;
  endsequence

  sequence s_pll_fall;
    $fell(chip_rst_state_out_o) && pll_cfg_i.pll_enable
      && pll_cfg_i.vco_ratio != 8'h00;
  endsequence

  a_hold_loaded: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    s_pin_released |=> s_hold_loaded)
    else $error("hold not loaded on release");

  a_bypass_length: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    s_bypass_fall |->
      hold_cyc_q == rst_seq_pkg::CNT_W'(rst_seq_pkg::HOLD_BYPASS_CYC))
    else $error("bypass hold length wrong");

  a_pll_length: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    s_pll_fall |->
      hold_cyc_q == rst_seq_pkg::CNT_W'(LOCK_BASE * pll_cfg_i.vco_ratio))
    else $error("PLL hold length wrong");

  // Output must stand for every cycle the sequencer is not running
  a_out_while_held: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    state_q != rst_seq_pkg::ST_RUN |-> chip_rst_state_out_o)
    else $error("reset state low while not running");

  // Once running, only a seen reset may raise the output again
  a_run_steady: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    (state_q == rst_seq_pkg::ST_RUN && !rst_seen)
      |=> !chip_rst_state_out_o)
    else $error("reset state rose without a reset");

  // A seen reset always leaves hold, wherever the count stands
  a_leave_hold: assert property (
    @(posedge clock_i) disable iff (!rstn_i)
    rst_seen |=> !in_hold(state_q))
    else $error("hold kept while reset seen");

endmodule

// ### verification/rst_supervisor.sv
// Board reset supervisor model driving the external active-low reset.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ns
module rst_supervisor (
  input  wire logic clock_i,
  output logic      ext_rst_n_o
);
  // Cold start: held low until the bench releases after settling
  initial ext_rst_n_o = 1'b0;
  // Never shorter than three clocks, or the sync chain may miss it
  task automatic assert_rst(input int low_cyc);
    @(posedge clock_i);
    #1 ext_rst_n_o = 1'b0;
    repeat ((low_cyc < 3) ? 3 : low_cyc) @(posedge clock_i);
  endtask
  task automatic release_rst();
    #1 ext_rst_n_o = 1'b1;
  endtask
endmodule

// ### verification/testbench.sv
// Self-checking bench for the reset synchroniser and state output.
// Assumes LOCK_BASE shortened to 4 cycles so PLL holds stay brief.
`timescale 1ns/1ns
module testbench;
  logic                  clock_i, rstn_i, ext_rst_n, state_o, core_n_o;
  rst_seq_pkg::pll_cfg_t cfg;
  int                    err_count, n_checks, cyc, rise_cyc, h, i;
  int                    exp_q[$];
  logic [31:0]           lfsr;
  reset_input_sync_and_status #(.LOCK_BASE(4)) dut (.clock_i(clock_i),
    .rstn_i(rstn_i), .ext_rst_n_i(ext_rst_n), .pll_cfg_i(cfg),
    .chip_rst_state_out_o(state_o), .core_rst_n_o(core_n_o));
  rst_supervisor sup (.clock_i(clock_i), .ext_rst_n_o(ext_rst_n));
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  always @(posedge clock_i) cyc <= cyc + 1;
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Next LFSR value; the only source of random stimulus
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Release reset and note the hold length the output must show
  task automatic release_note(input int hold);
    sup.release_rst();
    rise_cyc = cyc;
    exp_q.push_back(hold);
  endtask
  // Bounded wait for the state output to drop
  task automatic wait_low(input int lim);
    int k;
    for (k = 0; k < lim && state_o !== 1'b0; k++) @(posedge clock_i);
    if (k >= lim) begin
      err_count++;
      $display("CHECK FAILED %0t state output stuck", $time);
      print_verdict();
    end else begin
      @(posedge clock_i);
      #1 check(core_n_o === 1'b1, "core reset still low");
      $display("test done at %0t", $time);
    end
  endtask
  // Monitor: a fall takes the oldest note; latency slack is 8 cycles
  always @(negedge state_o) if (rstn_i === 1'b1 && exp_q.size() > 0) begin
    h = exp_q.pop_front();
    check(cyc - rise_cyc >= h && cyc - rise_cyc <= h + 8, "hold");
  end
  initial begin
    rstn_i = 1'b0;
    cfg = '0;
    cyc = 0;
    lfsr = 32'h4D77;
    repeat (8) @(posedge clock_i);
    #1 rstn_i = 1'b1;
    repeat (1000) @(posedge clock_i);
    release_note(512);
    wait_low(600);
    // Shortest hot reset must be seen within four edges
    sup.assert_rst(3);
    @(posedge clock_i);
    #1 check(state_o === 1'b1 && core_n_o === 1'b0, "entry");
    $display("test done at %0t", $time);
    // Re-assert during the hold: the count starts over
    sup.release_rst();
    repeat (100) @(posedge clock_i);
    sup.assert_rst(3);
    release_note(512);
    wait_low(600);
    // PLL holds with random ratios set while in reset
    for (i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      sup.assert_rst(3 + int'(lfsr[4:3]));
      #1 cfg = {1'b1, 8'(lfsr[2:0]) + 8'h01};
      release_note(4 * int'(cfg.vco_ratio));
      wait_low(60);
    end
    print_verdict();
  end
endmodule
